// >>> verilog/teletext_insertion.sv
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "teletext_cfg.svh"
// Behaviour
// R1 - Inserted data starts 9.78/10.5 us after sync.
// R2 - Source supplies one bit per request high.
// R3 - Programmable delay from request to valid data.
// R4 - Requests begin at programmed line position.
// R5 - PAL window holds 360 bits at 6.9375.
// R6 - 5.7272 rate: 296 WST, 288 NABTS bits.
// R7 - Enable bit zero keeps window closed.
// R8 - Insert only on programmed odd/even lines.
// R9 - Host configures shared pins before use; this block has no pin configuration of its own.
// R10 - Sample once per request, queue in order.
module teletext_insertion (
   input wire logic ref_clk,
   input wire logic rst,
   input teletext_pkg::reg_req_t reg_req,
   output logic [15:0] reg_rdata,
   input teletext_pkg::video_ref_t video_ref,
   input wire logic teletext_data_in,
   output logic teletext_request_out,
   output logic insert_valid,
   output logic insert_bit,
   output logic window_open
);
   import teletext_pkg::*;

   // Software registers.
   logic [15:0] ctrl_reg, ctrl_next;
   logic [5:0] delay_reg, delay_next; // Request-to-data delay in cycles.
   logic [10:0] start_reg, start_next; // Request start, cycles after sync.
   logic [9:0] odd_first_reg, odd_first_next;
   logic [9:0] odd_last_reg, odd_last_next;
   logic [9:0] even_first_reg, even_first_next;
   logic [9:0] even_last_reg, even_last_next;
   logic [15:0] rdata_reg, rdata_next;

   // Line timing and per-line decisions.
   logic [10:0] pos_reg, pos_next; // Cycles since the sync leading edge.
   logic line_act_reg, line_act_next; // This line carries teletext.
   ttx_std_t std_reg, std_next; // Standard latched at the line start.

   // Request side.
   phase_t req_ph_reg, req_ph_next;
   logic [23:0] req_acc_reg, req_acc_next;
   logic [8:0] req_cnt_reg, req_cnt_next;
   logic req_reg, req_next;
   logic [63:0] pipe_reg, pipe_next; // Delayed copies of the request.

   // Input synchroniser: three flip-flops, second and third must agree.
   logic [2:0] sync_reg, sync_next;
   logic din_reg, din_next;

   // Bit queue between sampling and insertion.
   logic [15:0] q_mem_reg, q_mem_next;
   logic [4:0] q_wp_reg, q_wp_next;
   logic [4:0] q_rp_reg, q_rp_next;

   // Insertion side.
   phase_t ins_ph_reg, ins_ph_next;
   logic [23:0] ins_acc_reg, ins_acc_next;
   logic [8:0] ins_cnt_reg, ins_cnt_next;
   logic ivalid_reg, ivalid_next;
   logic ibit_reg, ibit_next;

   // Combinational helpers.
   logic [23:0] step; // Rate accumulator step of the active standard.
   logic [8:0] nbits; // Window length in bits of the active standard.
   logic [10:0] t_ttx; // Insertion start after sync.
   logic [24:0] req_sum, ins_sum;
   logic sample_now, pop_now, q_empty, q_full;

   // Standard-dependent constants; a reserved code behaves as PAL.
   always_comb begin
      unique case (std_reg)
         STD_WST: begin
            step = `DTO_STEP_NTSC; // R6
            nbits = `BITS_WST; // R6
            t_ttx = `T_TTX_NTSC_CYC; // R1
         end
         STD_NABTS: begin
            step = `DTO_STEP_NTSC; // R6
            nbits = `BITS_NABTS; // R6
            t_ttx = `T_TTX_NTSC_CYC; // R1
         end
         default: begin
            step = `DTO_STEP_PAL; // R5
            nbits = `BITS_PAL; // R5
            t_ttx = `T_TTX_PAL_CYC; // R1
         end
      endcase
   end

   // Register writes and read data; reads answer one cycle later.
   always_comb begin
      ctrl_next = ctrl_reg;
      delay_next = delay_reg;
      start_next = start_reg;
      odd_first_next = odd_first_reg;
      odd_last_next = odd_last_reg;
      even_first_next = even_first_reg;
      even_last_next = even_last_reg;
      rdata_next = 16'h0000;
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            `REG_CTRL: ctrl_next = {13'h0000, reg_req.wdata[`CTRL_STD_MSB:0]};
            `REG_DATA_DELAY: delay_next = reg_req.wdata[5:0]; // R3
            `REG_START_POS: start_next = reg_req.wdata[10:0]; // R4
            `REG_ODD_FIRST: odd_first_next = reg_req.wdata[9:0];
            `REG_ODD_LAST: odd_last_next = reg_req.wdata[9:0];
            `REG_EVEN_FIRST: even_first_next = reg_req.wdata[9:0];
            `REG_EVEN_LAST: even_last_next = reg_req.wdata[9:0];
            `REG_STATUS: ; // Status is read only; writes are ignored.
         endcase
      end
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            `REG_CTRL: rdata_next = ctrl_reg;
            `REG_DATA_DELAY: rdata_next = {10'h000, delay_reg};
            `REG_START_POS: rdata_next = {5'h00, start_reg};
            `REG_ODD_FIRST: rdata_next = {6'h00, odd_first_reg};
            `REG_ODD_LAST: rdata_next = {6'h00, odd_last_reg};
            `REG_EVEN_FIRST: rdata_next = {6'h00, even_first_reg};
            `REG_EVEN_LAST: rdata_next = {6'h00, even_last_reg};
            `REG_STATUS: begin
               // Live state of the block for software to watch.
               rdata_next = {q_wp_reg - q_rp_reg, 7'h00, line_act_reg,
                             ivalid_reg, req_reg, window_open};
            end
         endcase
      end
   end

   // Line position and line qualification at each sync leading edge.
   always_comb begin
      pos_next = (pos_reg == `POS_MAX) ? pos_reg : pos_reg + 11'h001;
      line_act_next = line_act_reg;
      std_next = std_reg;
      if (video_ref.hsync_lead) begin
         pos_next = 11'h000;
         std_next = ttx_std_t'(ctrl_reg[`CTRL_STD_MSB:`CTRL_STD_LSB]);
         // Only enabled, programmed lines of the current field qualify.
         if (video_ref.field_odd) begin
            line_act_next = ctrl_reg[`CTRL_ENABLE_BIT] && // R7
               video_ref.line_num >= odd_first_reg &&
               video_ref.line_num <= odd_last_reg; // R8
         end else begin
            line_act_next = ctrl_reg[`CTRL_ENABLE_BIT] && // R7
               video_ref.line_num >= even_first_reg &&
               video_ref.line_num <= even_last_reg; // R8
         end
      end
   end

   // Request generator: one high cycle per wanted bit.
   always_comb begin
      req_ph_next = req_ph_reg;
      req_acc_next = req_acc_reg;
      req_cnt_next = req_cnt_reg;
      req_next = 1'b0;
      req_sum = {1'b0, req_acc_reg} + {1'b0, step};
      if (video_ref.hsync_lead) begin
         // A new line restarts the sequence; a late line is cut off here.
         req_ph_next = PH_WAIT;
         req_acc_next = 24'h000000;
         req_cnt_next = 9'h000;
      end else begin
         unique case (req_ph_reg)
            PH_IDLE: ;
            PH_WAIT: begin
               if (!line_act_reg) begin
                  req_ph_next = PH_IDLE;
               end else if (pos_reg == start_reg) begin
                  req_ph_next = PH_RUN; // R4
                  req_next = 1'b1;
                  req_cnt_next = 9'h001;
               end
            end
            PH_RUN: begin
               req_acc_next = req_sum[23:0];
               if (req_cnt_reg == nbits) begin
                  req_ph_next = PH_IDLE;
               end else if (req_sum[24]) begin
                  // Each carry of the rate accumulator asks for one bit.
                  req_next = 1'b1; // R2
                  req_cnt_next = req_cnt_reg + 9'h001;
               end
            end
            default: req_ph_next = PH_IDLE;
         endcase
      end
   end

   // Synchroniser, delay line and bit queue.
   always_comb begin
      sync_next = {sync_reg[1:0], teletext_data_in};
      // A change counts only once the second and third stages agree.
      din_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : din_reg;
      pipe_next = {pipe_reg[62:0], req_next};
      // The delay covers the source pipeline plus the input synchroniser.
      sample_now = pipe_reg[delay_reg]; // R3
      q_empty = (q_wp_reg == q_rp_reg);
      q_full = (q_wp_reg[3:0] == q_rp_reg[3:0]) && (q_wp_reg[4] != q_rp_reg[4]);
      pop_now = ins_ph_reg == PH_RUN && ins_sum[24] && ins_cnt_reg != nbits && !q_empty;
      q_mem_next = q_mem_reg;
      q_wp_next = q_wp_reg;
      q_rp_next = q_rp_reg;
      if (video_ref.hsync_lead) begin
         // Bits queued on the last line are dropped; its requests still in the delay line are queued in this one.
         q_wp_next = 5'h00;
         q_rp_next = 5'h00;
      end else begin
         if (sample_now && !q_full) begin
            q_mem_next[q_wp_reg[3:0]] = din_reg; // R10
            q_wp_next = q_wp_reg + 5'h01; // R10
         end
         if (pop_now) begin
            q_rp_next = q_rp_reg + 5'h01; // R10
         end
      end
   end

   // Insertion window: opens at the fixed time after sync, runs nbits bits.
   always_comb begin
      ins_ph_next = ins_ph_reg;
      ins_acc_next = ins_acc_reg;
      ins_cnt_next = ins_cnt_reg;
      ivalid_next = 1'b0;
      ibit_next = ibit_reg;
      ins_sum = {1'b0, ins_acc_reg} + {1'b0, step};
      if (video_ref.hsync_lead) begin
         ins_ph_next = PH_WAIT;
         ins_acc_next = 24'h000000;
         ins_cnt_next = 9'h000;
      end else begin
         unique case (ins_ph_reg)
            PH_IDLE: ;
            PH_WAIT: begin
               // Lines that do not qualify never open the window.
               if (!line_act_reg) begin
                  ins_ph_next = PH_IDLE; // R7
               end else if (pos_reg == t_ttx) begin
                  ins_ph_next = PH_RUN; // R1
               end
            end
            PH_RUN: begin
               ins_acc_next = ins_sum[23:0];
               if (ins_cnt_reg == nbits) begin
                  ins_ph_next = PH_IDLE; // R5
               end else if (ins_sum[24]) begin
                  // A missing bit from a slow source is inserted as zero.
                  ivalid_next = 1'b1;
                  ibit_next = q_empty ? 1'b0 : q_mem_reg[q_rp_reg[3:0]];
                  ins_cnt_next = ins_cnt_reg + 9'h001; // R6
               end
            end
            default: ins_ph_next = PH_IDLE;
         endcase
      end
   end

   // All state registers; asynchronous reset to constants only.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= `RST_CTRL;
         delay_reg <= `RST_DATA_DELAY;
         start_reg <= `RST_START_POS;
         odd_first_reg <= `RST_LINE;
         odd_last_reg <= `RST_LINE;
         even_first_reg <= `RST_LINE;
         even_last_reg <= `RST_LINE;
         rdata_reg <= 16'h0000;
         pos_reg <= `POS_MAX;
         line_act_reg <= 1'b0;
         std_reg <= STD_PAL;
         req_ph_reg <= PH_IDLE;
         req_acc_reg <= 24'h000000;
         req_cnt_reg <= 9'h000;
         req_reg <= 1'b0;
         pipe_reg <= 64'h0000000000000000;
         sync_reg <= 3'h0;
         din_reg <= 1'b0;
         q_mem_reg <= 16'h0000;
         q_wp_reg <= 5'h00;
         q_rp_reg <= 5'h00;
         ins_ph_reg <= PH_IDLE;
         ins_acc_reg <= 24'h000000;
         ins_cnt_reg <= 9'h000;
         ivalid_reg <= 1'b0;
         ibit_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         delay_reg <= delay_next;
         start_reg <= start_next;
         odd_first_reg <= odd_first_next;
         odd_last_reg <= odd_last_next;
         even_first_reg <= even_first_next;
         even_last_reg <= even_last_next;
         rdata_reg <= rdata_next;
         pos_reg <= pos_next;
         line_act_reg <= line_act_next;
         std_reg <= std_next;
         req_ph_reg <= req_ph_next;
         req_acc_reg <= req_acc_next;
         req_cnt_reg <= req_cnt_next;
         req_reg <= req_next;
         pipe_reg <= pipe_next;
         sync_reg <= sync_next;
         din_reg <= din_next;
         q_mem_reg <= q_mem_next;
         q_wp_reg <= q_wp_next;
         q_rp_reg <= q_rp_next;
         ins_ph_reg <= ins_ph_next;
         ins_acc_reg <= ins_acc_next;
         ins_cnt_reg <= ins_cnt_next;
         ivalid_reg <= ivalid_next;
         ibit_reg <= ibit_next;
      end
   end

   // Outputs straight from flip-flops, except the window flag, a state decode.
   assign reg_rdata = rdata_reg;
   assign teletext_request_out = req_reg; // R2
   assign insert_valid = ivalid_reg;
   assign insert_bit = ibit_reg;
   assign window_open = (ins_ph_reg == PH_RUN); // R7

endmodule : teletext_insertion

// >>> verilog/teletext_cfg.svh
`ifndef TELETEXT_CFG_SVH
`define TELETEXT_CFG_SVH
// Register word offsets on the plain register port.
`define REG_CTRL 3'h0
`define REG_DATA_DELAY 3'h1
`define REG_START_POS 3'h2
`define REG_ODD_FIRST 3'h3
`define REG_ODD_LAST 3'h4
`define REG_EVEN_FIRST 3'h5
`define REG_EVEN_LAST 3'h6
`define REG_STATUS 3'h7
// Control register fields.
`define CTRL_ENABLE_BIT 0
`define CTRL_STD_LSB 1
`define CTRL_STD_MSB 2
// Reset values of the writable registers.
`define RST_CTRL 16'h0000
`define RST_DATA_DELAY 6'h04
`define RST_START_POS 11'h040
`define RST_LINE 10'h000
// Clock period and documented times.
`define CLK_PERIOD_NS 100
`define T_TTX_PAL_NS 9780
`define T_TTX_NTSC_NS 10500
// Least times round up to whole cycles.
`define T_TTX_PAL_CYC (11'((`T_TTX_PAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define T_TTX_NTSC_CYC (11'((`T_TTX_NTSC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
// Bit rates and clock rate in units of 100 bit/s, for the rate accumulator.
`define RATE_PAL_HBPS 64'd69375
`define RATE_NTSC_HBPS 64'd57272
`define CLK_HHZ 64'd100000
`define DTO_FULL 64'd16777216
`define DTO_STEP_PAL (24'((`RATE_PAL_HBPS * `DTO_FULL) / `CLK_HHZ))
`define DTO_STEP_NTSC (24'((`RATE_NTSC_HBPS * `DTO_FULL) / `CLK_HHZ))
// Bits per insertion window.
`define BITS_PAL 9'd360
`define BITS_WST 9'd296
`define BITS_NABTS 9'd288
// Line position counter saturates here.
`define POS_MAX 11'h7FF
`endif

// >>> verilog/teletext_pkg.sv
package teletext_pkg;
   // Teletext standard selected in the control register.
   typedef enum logic [1:0] {
      STD_PAL = 2'b00,
      STD_WST = 2'b01,
      STD_NABTS = 2'b10,
      STD_RSVD = 2'b11
   } ttx_std_t;
   // Phase of one line's request or insertion sequence.
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_WAIT = 2'b01,
      PH_RUN = 2'b10
   } phase_t;
   // One register access from software.
   typedef struct packed {
      logic [2:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
   // Timing reference from the encoder's sync generator.
   typedef struct packed {
      logic hsync_lead;
      logic field_odd;
      logic [9:0] line_num;
   } video_ref_t;
endpackage : teletext_pkg

// >>> verification/teletext_checker.sv
`timescale 1ns/1ps
`include "teletext_cfg.svh"
// Port checker; it mirrors only the settings that its properties need.
module teletext_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input teletext_pkg::reg_req_t reg_req,
   input wire logic [15:0] reg_rdata,
   input teletext_pkg::video_ref_t video_ref,
   input wire logic teletext_data_in,
   input wire logic teletext_request_out,
   input wire logic insert_valid,
   input wire logic insert_bit,
   input wire logic window_open
);
   import teletext_pkg::*;
   logic en_reg, en_next, line_reg, line_next, seen_reg, seen_next; // Enable mirror and per-line flags.
   logic [10:0] start_reg, start_next, cnt_reg, cnt_next; // Start setting, cycles since sync.
   logic [5:0] dly_reg, dly_next; // Mirror of the data delay.
   // Writes update the mirrors; a sync pulse restarts the per-line trackers.
   always_comb begin
      en_next = en_reg;
      start_next = start_reg;
      dly_next = dly_reg;
      if (reg_req.wr && reg_req.addr == `REG_CTRL) en_next = reg_req.wdata[`CTRL_ENABLE_BIT];
      if (reg_req.wr && reg_req.addr == `REG_START_POS) start_next = reg_req.wdata[10:0];
      if (reg_req.wr && reg_req.addr == `REG_DATA_DELAY) dly_next = reg_req.wdata[5:0];
      line_next = video_ref.hsync_lead ? en_reg : line_reg;
      seen_next = !video_ref.hsync_lead && (seen_reg || teletext_request_out);
      cnt_next = (cnt_reg == `POS_MAX) ? cnt_reg : cnt_reg + 11'h001;
      if (video_ref.hsync_lead) cnt_next = 11'h000;
   end
   // Seen starts set, so no first-request check runs before the first line.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         {en_reg, line_reg, seen_reg} <= 3'h1;
         {start_reg, cnt_reg, dly_reg} <= {`RST_START_POS, `POS_MAX, `RST_DATA_DELAY};
      end else begin
         {en_reg, line_reg, seen_reg} <= {en_next, line_next, seen_next};
         {start_reg, cnt_reg, dly_reg} <= {start_next, cnt_next, dly_next};
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   sequence s_open; $rose(window_open); endsequence
   sequence s_held; window_open [*8]; endsequence
   property p_rdata_idle;
      !reg_req.rd |=> reg_rdata == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");
   property p_delay_read;
      reg_req.rd && reg_req.addr == `REG_DATA_DELAY |=> reg_rdata == {10'h000, dly_reg};
   endproperty
   a_delay_read: assert property (p_delay_read) else $error("delay read wrong");
   property p_no_window;
      !line_reg |-> !window_open;
   endproperty
   a_no_window: assert property (p_no_window) else $error("window on disabled line");
   property p_req_line;
      teletext_request_out |-> line_reg;
   endproperty
   a_req_line: assert property (p_req_line) else $error("request on disabled line");
   property p_insert_line;
      insert_valid |-> line_reg;
   endproperty
   a_insert_line: assert property (p_insert_line) else $error("insert on disabled line");
   property p_window_time;
      s_open |-> cnt_reg inside {11'd98, 11'd99, 11'd105, 11'd106};
   endproperty
   a_window_time: assert property (p_window_time) else $error("window opened off time");
   property p_first_req;
      teletext_request_out && !seen_reg |-> cnt_reg == start_reg + 11'h001;
   endproperty
   a_first_req: assert property (p_first_req) else $error("first request off place");
   property p_window_hold;
      s_open |-> s_held;
   endproperty
   a_window_hold: assert property (p_window_hold) else $error("window closed early");
endmodule : teletext_checker
bind teletext_insertion teletext_checker chk_i (.ref_clk(ref_clk), .rst(rst),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .video_ref(video_ref),
   .teletext_data_in(teletext_data_in), .teletext_request_out(teletext_request_out),
   .insert_valid(insert_valid), .insert_bit(insert_bit), .window_open(window_open));

// >>> verification/teletext_source.sv
`timescale 1ns/1ps
// Bit source: each request cycle yields one bit PIPE + 1 cycles later, held HOLD more
// cycles; after that the pin shows the inverse, so a late sample is caught.
module teletext_source #(
   parameter int PIPE = 2,
   parameter int HOLD = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic teletext_request_out,
   input wire logic line_bit,
   output logic teletext_data_in
);
   logic [7:0] req_hist_reg; // Request history, newest in bit 0.
   int idle; // Cycles since the last bit was presented.
   // Pipeline of request cycles to presented bits.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         req_hist_reg <= 8'h00;
         idle <= HOLD;
         teletext_data_in <= 1'b0;
      end else begin
         req_hist_reg <= {req_hist_reg[6:0], teletext_request_out};
         if (req_hist_reg[PIPE - 1]) begin
            teletext_data_in <= line_bit;
            idle <= 0;
         end else if (idle < HOLD) begin
            idle <= idle + 1;
         end else begin
            teletext_data_in <= ~line_bit;
         end
      end
   end
endmodule : teletext_source

// >>> verification/testbench.sv
`timescale 1ns/1ps
`include "teletext_cfg.svh"
// Self-checking bench; a source model answers the request output.
module testbench;
   import teletext_pkg::*;
   localparam int START = 84; // Early enough that the queue is primed before the window.
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   reg_req_t reg_req = '0;
   video_ref_t video_ref = '0;
   logic line_bit = 1'b0; // Bit the source sends on the current line.
   logic teletext_data_in, teletext_request_out, insert_valid, insert_bit, window_open;
   logic [15:0] reg_rdata;
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   teletext_insertion dut (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .video_ref(video_ref), .teletext_data_in(teletext_data_in),
      .teletext_request_out(teletext_request_out), .insert_valid(insert_valid),
      .insert_bit(insert_bit), .window_open(window_open));
   teletext_source #(.PIPE(2), .HOLD(4)) src (.ref_clk(ref_clk), .rst(rst),
      .teletext_request_out(teletext_request_out), .line_bit(line_bit),
      .teletext_data_in(teletext_data_in));
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   // A hang counts as a mismatch and ends the run.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 10000) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
      reg_req <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk);
      reg_req <= '0;
      @(posedge ref_clk);
   endtask : reg_wr
   // Read data stand only in the cycle after the strobe.
   task automatic reg_chk(input logic [2:0] a, input logic [15:0] exp);
      reg_req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge ref_clk);
      reg_req <= '0;
      #1 chk(reg_rdata, exp, "register read");
      @(posedge ref_clk);
   endtask : reg_chk
   // One line: sync pulse, then count requests, inserts and placement for 699 cycles.
   task automatic run_line(input logic odd, input logic [9:0] ln, input logic b,
      input int nreq, input int twin);
      int reqs = 0;
      int ins = 0;
      int bad = 0;
      int first = 0;
      int wopen = 0;
      line_bit <= b;
      video_ref <= '{1'b1, odd, ln};
      @(posedge ref_clk);
      video_ref.hsync_lead <= 1'b0;
      for (int k = 1; k < 700; k++) begin
         @(posedge ref_clk);
         #1;
         reqs += teletext_request_out;
         if (teletext_request_out && first == 0) first = k;
         if (window_open && wopen == 0) wopen = k;
         if (insert_valid) ins++;
         if (insert_valid) bad += (insert_bit !== b);
      end
      @(posedge ref_clk);
      chk(16'(reqs), 16'(nreq), "request count");
      chk(16'(ins), 16'(nreq), "insert count");
      chk(16'(bad), 16'h0000, "inserted bits");
      chk(16'(window_open), 16'h0000, "window closed");
      if (nreq > 0) begin
         chk(16'(first), 16'(START + 1), "first request");
         chk(16'(wopen == twin || wopen == twin + 1), 16'h0001, "window start");
      end else begin
         chk(16'(wopen), 16'h0000, "window opened");
      end
   endtask : run_line
   task automatic t_regs;
      logic [15:0] exp [8];
      exp = '{`RST_CTRL, 16'(`RST_DATA_DELAY), 16'(`RST_START_POS), 16'(`RST_LINE),
         16'(`RST_LINE), 16'(`RST_LINE), 16'(`RST_LINE), 16'h0000};
      for (int i = 0; i < 8; i++) reg_chk(3'(i), exp[i]);
      reg_wr(`REG_DATA_DELAY, 16'hFFFF);
      reg_chk(`REG_DATA_DELAY, 16'h003F);
      reg_wr(`REG_STATUS, 16'hFFFF);
      reg_chk(`REG_STATUS, 16'h0000);
      reg_wr(`REG_DATA_DELAY, 16'h0008);
      reg_wr(`REG_START_POS, 16'(START));
      reg_wr(`REG_ODD_FIRST, 16'h0014);
      reg_wr(`REG_ODD_LAST, 16'h0016);
      reg_wr(`REG_EVEN_FIRST, 16'h012C);
      reg_wr(`REG_EVEN_LAST, 16'h012D);
      reg_chk(`REG_EVEN_LAST, 16'h012D);
   endtask : t_regs
   task automatic t_enable;
      reg_wr(`REG_CTRL, 16'h0000);
      run_line(1'b1, 10'd21, 1'b1, 0, 98);
   endtask : t_enable
   // Every standard code, the spare one behaving as the first.
   task automatic t_standards;
      int nb [4] = '{360, 296, 288, 360};
      int tw [4] = '{98, 105, 105, 98};
      for (int s = 0; s < 4; s++) begin
         reg_wr(`REG_CTRL, {13'h0000, 2'(s), 1'b1});
         run_line(1'b1, 10'd20, s[0], nb[s], tw[s]);
      end
   endtask : t_standards
   // Range edges in both fields.
   task automatic t_lines;
      reg_wr(`REG_CTRL, 16'h0003);
      run_line(1'b0, 10'd301, 1'b1, 296, 105); // even last line
      run_line(1'b0, 10'd21, 1'b0, 0, 105); // odd range seen in even field
      run_line(1'b1, 10'd23, 1'b1, 0, 105); // past odd last line
      run_line(1'b1, 10'd22, 1'b0, 296, 105); // odd last line
   endtask : t_lines
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_regs();
      t_enable();
      t_standards();
      t_lines();
      // The last line qualified and every queued bit has been inserted, so only line active stands.
      reg_chk(`REG_STATUS, 16'h0008);
      close_out();
   end
endmodule : testbench
